// file: design/kse_key_scan_encoder.sv
// Notes on behaviour
// RULE1: keys form a 16 by 16 grid addressed by column and row.
// RULE2: exactly one column line driven at a time, stepping through all columns.
// RULE3: count scan cycles on closure, drop unsustained ones, serve closures in order.
// RULE4: threshold raised with no closure, lowered on a valid closure.
// RULE5: valid closure loads the current key code into the eight-bit latch.
// RULE6: low four code bits are the row count at load.
// RULE7: high four code bits come from the ROM, addressed by column and function bits.
// RULE8: every load fires one 6 us ready pulse to the host.
// RULE9: latch holds eight bits; low seven are the character code.
// RULE10: top code bit set only for special control keys.
// RULE11: host fetches the code by reading the keyboard input port.
// RULE12: repeat key plus held character key gives periodic repeat strobes.
// RULE13: repeat strobe fires another ready pulse without reloading the latch.
// RULE14: no latch load while repeating.
// RULE15: on the function column, the function latch captures the low row count.
// RULE16: local, reset, break go out; shift, upper case, control go to the ROM.
// RULE17: shift, upper case and control are three of seven ROM address bits.
// RULE18: all sixteen rows tested before the column advances.
// RULE19: output only after two consecutive detections at one scan address.
// RULE20: latched code stays stable until the next load.
`timescale 1ns/1ps
`default_nettype none
module kse_key_scan_encoder
  import kse_pkg::*;
#(
  parameter int unsigned ROW_STEP   = ROW_STEP_CYC,
  parameter int unsigned STROBE_LEN = STROBE_CYC,
  parameter int unsigned REP_SCANS  = REPEAT_SCANS
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        key_sense,
  output var  logic [15:0] column_drive,
  output var  logic [3:0]  row_select,
  output var  logic        sense_threshold_ctrl,
  output var  logic        ready_strobe,
  output var  logic [7:0]  key_code_bits,
  output var  logic        special_key_flag,
  output var  logic        local_mode,
  output var  logic        reset_request,
  output var  logic        break_request
);

  localparam int unsigned SW = $clog2(ROW_STEP);
  localparam int unsigned RW = $clog2(REP_SCANS + 1);

  kse_pos_t    pos_reg;
  kse_pos_t    addr_reg;
  kse_state_t  state_reg;
  kse_state_t  state_next;
  logic [SW-1:0] step_cnt_reg;
  logic [RW-1:0] scan_cnt_reg;
  logic [7:0]  func_reg;
  logic [7:0]  code_reg;
  logic [1:0]  ctrl_reg;
  logic [15:0] col_drive_reg;
  logic        thr_reg;
  logic        trigger_reg;
  logic        rep_pulse_reg;
  logic        load_now;
  logic        rep_now;
  logic        step_tick;
  logic        hit;
  logic        at_addr;
  logic        repeat_act;
  logic [3:0]  rom_q;
  logic [6:0]  rom_addr;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic        setup_phase;
  logic        keyboard_port_read;

  function automatic logic [15:0] col_onehot(input logic [3:0] c);
    return 16'h0001 << c;
  endfunction

  function automatic logic addr_mapped(input logic [11:0] a);
    return (a == KEY_CODE_OFS) || (a == STATUS_OFS) || (a == CTRL_OFS);
  endfunction

  // scan timing
  assign step_tick = ctrl_reg[CTRL_SCAN_EN] && (step_cnt_reg == SW'(ROW_STEP - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_cnt_reg <= '0;
    end else if (!ctrl_reg[CTRL_SCAN_EN] || step_tick) begin
      step_cnt_reg <= '0;
    end else begin
      step_cnt_reg <= step_cnt_reg + 1'b1;
    end
  end

  // row counts fastest; the column only steps on row wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_reg       <= '0;
      col_drive_reg <= 16'h0001;
    end else if (step_tick) begin
      pos_reg.row <= pos_reg.row + 4'h1; // RULE1
      if (pos_reg.row == LAST_ROW) begin
        pos_reg.col   <= pos_reg.col + 4'h1; // RULE18
        col_drive_reg <= col_onehot(pos_reg.col + 4'h1); // RULE2
      end
    end
  end

  assign column_drive = col_drive_reg;
  assign row_select   = pos_reg.row;

  // function latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      func_reg <= FUNC_RESET;
    end else if (step_tick && pos_reg.col == FUNC_COL && !pos_reg.row[3]) begin
      func_reg[pos_reg.row[2:0]] <= key_sense; // RULE15
    end
  end

  assign local_mode    = func_reg[F_LOCAL]; // RULE16
  assign reset_request = func_reg[F_RESET];
  assign break_request = func_reg[F_BREAK];

  assign rom_addr = {func_reg[F_CTRL], func_reg[F_UPPER],
                     func_reg[F_SHIFT] | func_reg[F_LOCK], pos_reg.col}; // RULE17

  kse_code_rom u_rom (
    .pclk     (pclk),
    .presetn  (presetn),
    .addr     (rom_addr),
    .data_reg (rom_q)
  );

  // sequence detector
  // function keys never start a closure; they only feed the latch
  assign hit        = step_tick && key_sense && (pos_reg.col != FUNC_COL);
  assign at_addr    = step_tick && (pos_reg == addr_reg);
  assign repeat_act = (state_reg == S_HELD) && func_reg[F_REPEAT] && ctrl_reg[CTRL_REPEAT_EN]; // RULE12
  assign load_now   = (state_reg == S_ARMED) && at_addr && key_sense && !repeat_act; // RULE19 RULE14
  assign rep_now    = repeat_act && at_addr && key_sense && (scan_cnt_reg == RW'(REP_SCANS - 1));

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      S_IDLE: begin
        if (hit) begin
          state_next = S_ARMED;
        end
      end
      S_ARMED: begin
        if (at_addr) begin
          state_next = key_sense ? S_HELD : S_IDLE; // RULE3
        end
      end
      S_HELD: begin
        if (at_addr && !key_sense) begin
          state_next = S_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= S_IDLE;
      addr_reg  <= '0;
    end else begin
      state_reg <= state_next;
      // first closure seen owns the detector until released
      if (state_reg == S_IDLE && hit) begin
        addr_reg <= pos_reg; // RULE3
      end
    end
  end

  // passes counted only while repeating, so the first repeat comes a full period after enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_cnt_reg <= '0;
    end else if (!repeat_act || rep_now) begin // RULE12
      scan_cnt_reg <= '0;
    end else if (at_addr && key_sense) begin
      scan_cnt_reg <= scan_cnt_reg + 1'b1; // RULE3
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thr_reg <= 1'b1;
    end else begin
      thr_reg <= (state_next != S_HELD); // RULE4
    end
  end

  assign sense_threshold_ctrl = thr_reg;

  // output latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_reg <= CODE_RESET;
    end else if (load_now) begin
      code_reg <= {rom_q, pos_reg.row}; // RULE5 RULE6 RULE7 RULE9 RULE10 RULE20
    end
  end

  assign key_code_bits    = code_reg;
  assign special_key_flag = code_reg[7]; // RULE10

  // strobe generator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trigger_reg   <= 1'b0;
      rep_pulse_reg <= 1'b0;
    end else begin
      trigger_reg   <= load_now || rep_now; // RULE8 RULE13
      rep_pulse_reg <= rep_now;
    end
  end

  kse_strobe_gen #(
    .LEN (STROBE_LEN)
  ) u_strobe (
    .pclk       (pclk),
    .presetn    (presetn),
    .trigger    (trigger_reg),
    .strobe_reg (ready_strobe)
  );

  // apb slave
  assign setup_phase        = psel && !penable;
  assign keyboard_port_read = setup_phase && !pwrite && (paddr == KEY_CODE_OFS); // RULE11

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RESET;
    end else if (psel && penable && pwrite && pready_reg && paddr == CTRL_OFS) begin
      ctrl_reg <= pwdata[1:0];
    end
  end

  // read data captured in setup so the access phase answers at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
      pready_reg  <= 1'b0;
    end else begin
      pready_reg <= 1'b1;
      if (setup_phase) begin
        pslverr_reg <= !addr_mapped(paddr);
        prdata_reg  <= 32'h0000_0000;
        if (keyboard_port_read) begin
          prdata_reg[7:0] <= code_reg;
        end else if (!pwrite && paddr == STATUS_OFS) begin
          prdata_reg[ST_ROW_LSB +: 4]   <= pos_reg.row;
          prdata_reg[ST_COL_LSB +: 4]   <= pos_reg.col;
          prdata_reg[ST_STATE_LSB +: 3] <= state_reg;
          prdata_reg[ST_REPEAT]         <= repeat_act;
          prdata_reg[ST_FUNC_LSB +: 8]  <= func_reg;
        end else if (!pwrite && paddr == CTRL_OFS) begin
          prdata_reg[1:0] <= ctrl_reg;
        end
      end
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

  // checks
  int unsigned hi_cnt_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_cnt_reg <= 0;
    end else if (trigger_reg) begin
      hi_cnt_reg <= 0;
    end else if (ready_strobe) begin
      hi_cnt_reg <= hi_cnt_reg + 1;
    end
  end

  a_one_column_hot: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
    $onehot(column_drive) && column_drive == col_onehot(pos_reg.col))
    else $error("column drive not one-hot on the scanned column");

  a_rows_before_col: assert property (@(posedge pclk) disable iff (!presetn) // RULE18
    $changed(pos_reg.col) |-> $past(pos_reg.row) == LAST_ROW && pos_reg.row == 4'h0)
    else $error("column advanced before all rows tested");

  a_thr_held_low: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
    (state_reg == S_HELD) |-> !sense_threshold_ctrl)
    else $error("threshold not lowered on valid closure");

  a_thr_idle_high: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
    (state_reg != S_HELD) |-> sense_threshold_ctrl)
    else $error("threshold not raised without closure");

  a_two_detects: assert property (@(posedge pclk) disable iff (!presetn) // RULE19
    load_now |-> $past(state_reg == S_ARMED) && key_sense && pos_reg == addr_reg)
    else $error("load without second detection at same address");

  a_code_low_row: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
    load_now |=> key_code_bits[3:0] == $past(pos_reg.row) && key_code_bits[7:4] == $past(rom_q))
    else $error("latched code does not match row count and ROM");

  a_code_stable: assert property (@(posedge pclk) disable iff (!presetn) // RULE20
    !load_now |=> $stable(key_code_bits))
    else $error("key code changed without a load");

  a_strobe_width: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    $fell(ready_strobe) |-> hi_cnt_reg == STROBE_LEN)
    else $error("ready pulse length wrong");

  a_load_strobes: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    load_now |-> ##2 ready_strobe)
    else $error("load did not start a ready pulse");

  a_repeat_no_load: assert property (@(posedge pclk) disable iff (!presetn) // RULE13
    rep_pulse_reg |-> ##1 ready_strobe ##0 $stable(key_code_bits))
    else $error("repeat strobe missing or latch reloaded");

  a_func_capture: assert property (@(posedge pclk) disable iff (!presetn) // RULE15
    (step_tick && pos_reg.col == FUNC_COL && !pos_reg.row[3])
      |=> func_reg[$past(pos_reg.row[2:0])] == $past(key_sense))
    else $error("function latch missed its row");

  c_key_load:  cover property (@(posedge pclk) disable iff (!presetn) load_now);
  c_repeat:    cover property (@(posedge pclk) disable iff (!presetn) rep_pulse_reg);
  c_reject:    cover property (@(posedge pclk) disable iff (!presetn)
    state_reg == S_ARMED && at_addr && !key_sense);
  c_special:   cover property (@(posedge pclk) disable iff (!presetn) load_now ##1 special_key_flag);

endmodule
`default_nettype wire

// file: design/kse_pkg.sv
package kse_pkg;

  // timing
  localparam int unsigned CLK_PERIOD_NS   = 5;
  localparam int unsigned ROW_STEP_NS     = 6000;
  localparam int unsigned STROBE_NS       = 6000;
  localparam int unsigned ROW_STEP_CYC    = (ROW_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STROBE_CYC      = STROBE_NS / CLK_PERIOD_NS;
  localparam int unsigned REPEAT_SCANS    = 16;

  // matrix geometry
  localparam int unsigned NUM_COLS        = 16;
  localparam int unsigned NUM_ROWS        = 16;
  localparam logic [3:0]  FUNC_COL        = 4'hf;
  localparam logic [3:0]  SPECIAL_COL     = 4'he;
  localparam logic [3:0]  LAST_ROW        = 4'hf;

  // function latch bit positions (row within the function column)
  localparam int unsigned F_SHIFT         = 0;
  localparam int unsigned F_LOCK          = 1;
  localparam int unsigned F_UPPER         = 2;
  localparam int unsigned F_CTRL          = 3;
  localparam int unsigned F_LOCAL         = 4;
  localparam int unsigned F_RESET         = 5;
  localparam int unsigned F_BREAK         = 6;
  localparam int unsigned F_REPEAT        = 7;

  // register offsets (byte addresses)
  localparam logic [11:0] KEY_CODE_OFS    = 12'h000;
  localparam logic [11:0] STATUS_OFS      = 12'h004;
  localparam logic [11:0] CTRL_OFS        = 12'h008;

  // control fields
  localparam int unsigned CTRL_SCAN_EN    = 0;
  localparam int unsigned CTRL_REPEAT_EN  = 1;
  localparam logic [1:0]  CTRL_RESET      = 2'h3;

  // status fields
  localparam int unsigned ST_ROW_LSB      = 0;
  localparam int unsigned ST_COL_LSB      = 4;
  localparam int unsigned ST_STATE_LSB    = 8;
  localparam int unsigned ST_REPEAT       = 11;
  localparam int unsigned ST_FUNC_LSB     = 16;

  localparam logic [7:0]  CODE_RESET      = 8'h00;
  localparam logic [7:0]  FUNC_RESET      = 8'h00;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b001,
    S_ARMED = 3'b010,
    S_HELD  = 3'b100
  } kse_state_t;

  typedef struct packed {
    logic [3:0] col;
    logic [3:0] row;
  } kse_pos_t;

endpackage

// file: design/kse_code_rom.sv
`timescale 1ns/1ps
`default_nettype none
module kse_code_rom
  import kse_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [6:0] addr,
  output var  logic [3:0] data_reg
);

  // addr = {control, upper case, shift or lock, column}
  function automatic logic [3:0] rom_entry(input logic [6:0] a);
    logic [3:0] c;
    logic [3:0] n;
    c = a[3:0];
    if (c < 4'h2) begin
      n = 4'h2;
    end else if (c < 4'h4) begin
      n = 4'h3;
    end else if (c < 4'h8) begin
      n = c[0] ? 4'h5 : 4'h4;
    end else if (c < 4'hc) begin
      n = c[0] ? 4'h7 : 4'h6;
    end else if (c < SPECIAL_COL) begin
      n = 4'h2;
    end else if (c == SPECIAL_COL) begin
      n = 4'h8;
    end else begin
      n = 4'h0;
    end
    if (a[4] && n == 4'h3) begin
      n = 4'h2;
    end
    // letters fold to upper case under shift, lock or upper case
    if ((a[4] || a[5]) && (n == 4'h6 || n == 4'h7)) begin
      n = n - 4'h2;
    end
    if (a[6] && n >= 4'h4 && n <= 4'h7) begin
      n = {3'h0, n[0]};
    end
    return n;
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_reg <= 4'h0;
    end else begin
      data_reg <= rom_entry(addr);
    end
  end

endmodule
`default_nettype wire

// file: design/kse_strobe_gen.sv
`timescale 1ns/1ps
`default_nettype none
module kse_strobe_gen
  import kse_pkg::*;
#(
  parameter int unsigned LEN = STROBE_CYC
)(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic trigger,
  output var  logic strobe_reg
);

  localparam int unsigned CW = $clog2(LEN + 1);

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;

  always_comb begin
    if (trigger) begin
      cnt_next = CW'(LEN);
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1;
    end else begin
      cnt_next = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg    <= '0;
      strobe_reg <= 1'b0;
    end else begin
      cnt_reg    <= cnt_next;
      strobe_reg <= (cnt_next != '0);
    end
  end

endmodule
`default_nettype wire

// file: verif/kse_key_matrix_model.sv
`timescale 1ns/1ps
`default_nettype none
module kse_key_matrix_model
  import kse_pkg::*;
(
  input  wire logic [15:0]  column_drive,
  input  wire logic [3:0]   row_select,
  input  wire logic [255:0] pressed,
  output var  logic         key_sense
);
  // a key only couples when its own column is driven and its row tested
  always_comb begin
    key_sense = 1'b0;
    for (int c = 0; c < NUM_COLS; c++) begin
      if (column_drive[c]) begin
        key_sense = key_sense | pressed[{c[3:0], row_select}];
      end
    end
  end
endmodule
`default_nettype wire

// file: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import kse_pkg::*;
  localparam int unsigned RS   = 4;
  localparam int unsigned SL   = 8;
  localparam int unsigned RP   = 2;
  localparam int unsigned SCAN = 256 * RS;
  logic         pclk = 1'b0;
  logic         presetn = 1'b0;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic [11:0]  paddr = 12'h000;
  logic [31:0]  pwdata = 32'h0000_0000;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic         key_sense;
  logic [15:0]  column_drive;
  logic [3:0]   row_select;
  logic         sense_threshold_ctrl;
  logic         ready_strobe;
  logic [7:0]   key_code_bits;
  logic         special_key_flag;
  logic         local_mode;
  logic         reset_request;
  logic         break_request;
  logic [255:0] pressed = '0;
  logic         rs_d = 1'b0;
  int           rises = 0;
  int           bad_count = 0;
  int           checks = 0;

  initial begin
    forever #2.5 pclk = ~pclk;
  end

  kse_key_scan_encoder #(.ROW_STEP(RS), .STROBE_LEN(SL), .REP_SCANS(RP)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .key_sense(key_sense), .column_drive(column_drive), .row_select(row_select),
    .sense_threshold_ctrl(sense_threshold_ctrl), .ready_strobe(ready_strobe),
    .key_code_bits(key_code_bits), .special_key_flag(special_key_flag), .local_mode(local_mode),
    .reset_request(reset_request), .break_request(break_request)
  );

  kse_key_matrix_model u_keys (
    .column_drive(column_drive), .row_select(row_select), .pressed(pressed), .key_sense(key_sense)
  );

  // strobe events counted as they happen, scenarios compare snapshots
  always @(posedge pclk) begin
    rs_d <= ready_strobe;
    if (ready_strobe === 1'b1 && rs_d !== 1'b1) begin
      rises <= rises + 1;
    end
  end

  task automatic summarize();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("ERROR at %0t: %s", $time, msg);
    end
  endtask

  task automatic hang(input string msg);
    check(1'b0, msg);
    summarize();
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 50) hang("apb no pready");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // skip any visit in progress so a press always precedes the sample edge
  task automatic wait_pos(input int c, input int r);
    int n;
    for (n = 0; n < 3 * SCAN; n++) begin
      @(posedge pclk);
      if (column_drive === 16'h0001 << c && row_select === r[3:0]) continue;
      break;
    end
    for (n = 0; n < 3 * SCAN; n++) begin
      @(posedge pclk);
      if (column_drive === 16'h0001 << c && row_select === r[3:0]) return;
    end
    hang("scan position never reached");
  endtask

  task automatic wait_rise(output int len);
    int n;
    len = 0;
    for (n = 0; n < 3 * SCAN; n++) begin
      @(posedge pclk);
      if (ready_strobe === 1'b1) break;
    end
    if (n == 3 * SCAN) hang("no ready strobe");
    len = 1;
    for (n = 0; n < 4 * SL; n++) begin
      @(posedge pclk);
      if (ready_strobe !== 1'b1) break;
      len++;
    end
  endtask

  task automatic t_scan();
    logic [15:0] pc;
    logic [3:0]  pr;
    int          cols;
    logic [31:0] rd;
    logic        err;
    cols = 0;
    pc = column_drive;
    pr = row_select;
    for (int i = 0; i < SCAN + 8; i++) begin
      @(posedge pclk);
      if (column_drive !== pc) begin
        cols++;
        check($onehot(column_drive), "column drive not one-hot");
        check(pr === LAST_ROW && row_select === 4'h0, "column moved before all rows");
      end
      pc = column_drive;
      pr = row_select;
    end
    check(cols >= NUM_COLS, "not every column visited");
    // scan enable cleared: the position must freeze
    apb(1'b1, CTRL_OFS, 32'h0000_0002, rd, err);
    tick(1);
    pc = column_drive;
    pr = row_select;
    tick(4 * RS * NUM_ROWS);
    check(column_drive === pc && row_select === pr, "scan moved while disabled");
    apb(1'b1, CTRL_OFS, 32'h0000_0003, rd, err);
  endtask

  task automatic t_ctrl();
    int len;
    pressed[{FUNC_COL, 4'(F_CTRL)}] <= 1'b1;
    tick(SCAN + RS);
    pressed[{4'd4, 4'd1}] <= 1'b1;
    wait_rise(len);
    check(key_code_bits === 8'h01, "control state did not reach the rom");
    pressed <= '0;
    tick(2 * SCAN);
  endtask

  task automatic t_noise();
    int          r0;
    logic [7:0]  code;
    code = key_code_bits;
    r0 = rises;
    wait_pos(3, 5);
    pressed[{4'd3, 4'd5}] <= 1'b1;
    tick(RS + 1);
    pressed <= '0;
    tick(2 * SCAN);
    check(rises == r0, "single detection produced a strobe");
    check(key_code_bits === code, "single detection loaded a code");
    check(sense_threshold_ctrl === 1'b1, "threshold lowered without closure");
  endtask

  task automatic t_press(input int c, input int r);
    int          len;
    int          r0;
    logic [7:0]  code;
    logic [31:0] rd;
    logic        err;
    pressed[{c[3:0], r[3:0]}] <= 1'b1;
    wait_rise(len);
    code = key_code_bits;
    check(len == SL, "ready pulse length");
    check(code[3:0] === r[3:0], "low code bits not the row");
    check(code[7] === (c == SPECIAL_COL), "special flag wrong for column");
    if (c == SPECIAL_COL) check(code[7:4] === 4'h8, "rom nibble for special column");
    check(special_key_flag === code[7], "special flag output");
    check(sense_threshold_ctrl === 1'b0, "threshold not lowered");
    apb(1'b0, KEY_CODE_OFS, 32'h0000_0000, rd, err);
    check(rd[7:0] === code && err === 1'b0, "key code port read");
    pressed <= '0;
    r0 = rises;
    tick(2 * SCAN);
    check(sense_threshold_ctrl === 1'b1, "threshold not raised after release");
    check(key_code_bits === code && rises == r0, "code changed without load");
  endtask

  task automatic t_repeat();
    int          len;
    int          r0;
    logic [7:0]  code;
    logic [31:0] rd;
    logic        err;
    apb(1'b1, CTRL_OFS, 32'h0000_0003, rd, err);
    pressed[{4'd4, 4'd1}] <= 1'b1;
    wait_rise(len);
    code = key_code_bits;
    pressed[{FUNC_COL, 4'd7}] <= 1'b1;
    pressed[{FUNC_COL, 4'd6}] <= 1'b1;
    tick(SCAN + RS);
    check(break_request === 1'b1 && local_mode === 1'b0 && reset_request === 1'b0, "break indication");
    apb(1'b0, STATUS_OFS, 32'h0000_0000, rd, err);
    check(rd[ST_FUNC_LSB + F_REPEAT] === 1'b1, "function latch repeat bit");
    r0 = rises;
    tick(8 * SCAN);
    check(rises - r0 >= 2, "no repeat strobes");
    check(key_code_bits === code, "repeat reloaded the latch");
    apb(1'b1, CTRL_OFS, 32'h0000_0001, rd, err);
    tick(SCAN);
    r0 = rises;
    tick(6 * SCAN);
    check(rises == r0, "repeat with repeat disabled");
    pressed <= '0;
    tick(2 * SCAN);
  endtask

  initial begin
    logic [31:0] rd;
    logic        err;
    tick(20);
    check(column_drive === 16'h0001 && sense_threshold_ctrl === 1'b1, "reset scan state");
    check(key_code_bits === CODE_RESET && ready_strobe === 1'b0, "reset code state");
    presetn <= 1'b1;
    apb(1'b0, CTRL_OFS, 32'h0000_0000, rd, err);
    check(rd[1:0] === CTRL_RESET, "ctrl reset value");
    apb(1'b0, 12'hff0, 32'h0000_0000, rd, err);
    check(err === 1'b1 && rd === 32'h0000_0000, "unmapped read");
    apb(1'b1, KEY_CODE_OFS, 32'h0000_00a5, rd, err);
    apb(1'b0, KEY_CODE_OFS, 32'h0000_0000, rd, err);
    check(rd[7:0] === CODE_RESET, "read-only code written");
    t_scan();
    t_noise();
    t_press(3, 5);
    t_press(SPECIAL_COL, 2);
    t_ctrl();
    t_repeat();
    summarize();
  end
endmodule
`default_nettype wire
